// File: shared/spag_pkg.sv
// Purpose: Shared constants and types for scratch pad address generation
// Assumes: Seven-bit fast memory address, five-bit selector
// Notes:   Selector codes are written as hex constants, with the octal value in each comment
package spag_pkg;
   localparam int SEL_W  = 5;
   localparam int ADDR_W = 7;
   localparam int GEN_W  = 4;
   localparam int IT_W   = 3;

   localparam logic [SEL_W-1:0]  SEL_RESET   = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET  = 7'h00;

   localparam logic [SEL_W-1:0] SEL_COUNTER  = 5'h01; // octal 01
   localparam logic [SEL_W-1:0] SEL_GEN_MOST = 5'h02; // octal 02
   localparam logic [SEL_W-1:0] SEL_GEN_LST  = 5'h03; // octal 03
   localparam logic [SEL_W-1:0] SEL_NM_CTR   = 5'h04; // octal 04
   localparam logic [SEL_W-1:0] SEL_IO_AREA  = 5'h05; // octal 05
   localparam logic [SEL_W-1:0] SEL_PARITY   = 5'h06; // octal 06
   localparam logic [SEL_W-1:0] SEL_FIX43    = 5'h07; // octal 07
   localparam logic [SEL_W-1:0] SEL_GPR_M    = 5'h10; // octal 20
   localparam logic [SEL_W-1:0] SEL_GPR_M_O  = 5'h11; // octal 21
   localparam logic [SEL_W-1:0] SEL_GPR_L    = 5'h12; // octal 22
   localparam logic [SEL_W-1:0] SEL_GPR_L_O  = 5'h13; // octal 23
   localparam logic [SEL_W-1:0] SEL_INT_MASK = 5'h18; // octal 30
   localparam logic [SEL_W-1:0] SEL_INT_STAT = 5'h19; // octal 31
   localparam logic [SEL_W-1:0] SEL_PROG_CTR = 5'h1a; // octal 32

   localparam logic [ADDR_W-1:0] ADDR_PARITY = 7'h70;
   localparam logic [ADDR_W-1:0] ADDR_FIX43  = 7'h43;
   localparam logic [3:0]        GEN_HI_BITS = 4'he;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_MUX,
      MODE_SELCHAN,
      MODE_IDLE
   } spag_mode_type;

   typedef struct packed {
      logic [ADDR_W-1:0] counter;
      logic [GEN_W-1:0]  general_field_most;
      logic [GEN_W-1:0]  general_field_least;
      logic [1:0]        program_state_reg;
      logic [IT_W-1:0]   init_term_reg;
   } spag_src_type;
endpackage : spag_pkg

// File: logic/spag_addr_gen.sv
// Purpose: Selector register and fast memory address decode for the scratch pad
// Assumes: Pulses and sources come from logic on CLK_I; no clock crossing
// Notes:   Fixed utility table folded into the decoder; mode override applied after it
`timescale 1ns/1ps

// Functional notes
// [RULE1] Selector register loads from set lines on the load pulse.
// [RULE2] Memory access happens on access pulse using the decoded address.
// [RULE3] Decoder output, seven bits, loads the fast memory address register.
// [RULE4] Selector flip-flops are set from the encoded selector set lines.
// [RULE5] Bits 4..3 form high octal digit, bits 2..0 the low digit.
// [RULE6] Code 01 takes all seven address bits from the iteration counter.
// [RULE7] Codes 02/03 give 1110 plus general field low three bits.
// [RULE8] Codes 06 and 07 give fixed addresses 70 and 43 hex.
// [RULE9] Codes 10..17 give utility addresses 00,01,60,61,06,07,A0,A1; the code gives 00,01,30,31,06,07,50,51 hex.
// [RULE10] Codes 20/22: state bits high, zero, then full general field.
// [RULE11] Codes 21/23 as 20/22 but address bit 0 forced to one.
// [RULE12] Codes 24..27: state bits, zero, state pattern, then 00..11.
// [RULE13] Codes 30..32: bit5 only in state 4, state bits at 3..2.
// [RULE14] Selector bit 4 low makes the address independent of program state.
// [RULE15] Digit 10 uses state at bits 6,5; digit 11 at 5,3,2.
// [RULE16] State bits 11,10,01,00 mean program states 1,2,3,4.
// [RULE17] Code 05 addresses the I/O area from initiate/terminate and counter.
// [RULE18] I/O channel bits come from current initiate/terminate contents.
// [RULE19] Mux and selector-channel modes use their own address registers.
// [RULE20] Command logic derives controls from pulses, op codes, flip-flops.
// [RULE21] Command logic issues reset, load and trigger controls.
// [RULE22] Undefined codes give address zero and no memory access.
// [RULE23] Decoded address holds from access pulse until the access ends.
module spag_addr_gen #(
   parameter int SEL_WIDTH = spag_pkg::SEL_W
) (
   input  wire logic                         CLK_I,
   input  wire logic                         SRST_I,
   input  wire logic                         LOAD_PULSE_I,
   input  wire logic                         ACCESS_PULSE_I,
   input  wire logic                         ACCESS_DONE_I,
   input  wire logic [SEL_WIDTH-1:0]         SELECTOR_SET_LINES_I,
   input  wire spag_pkg::spag_mode_type      MODE_I,
   input  wire spag_pkg::spag_src_type       SRC_I,
   input  wire logic [spag_pkg::ADDR_W-1:0]  MUX_SCRATCH_ADDR_REG_I,
   input  wire logic [spag_pkg::ADDR_W-1:0]  SELCHAN_SCRATCH_ADDR_REG_I,
   output logic [SEL_WIDTH-1:0]              SCRATCH_ADDR_SELECTOR_O,
   output logic [spag_pkg::ADDR_W-1:0]       FAST_MEM_ADDR_BITS_O,
   output logic                              MEM_ACCESS_O,
   output logic                              ADDR_VALID_O
);
   import spag_pkg::*;

   // ==========================================================
   // Helpers
   // ==========================================================
   // [RULE16] State bits to program state 1..4
   function automatic logic [2:0] prog_state(input logic [1:0] pst);
      logic [2:0] n;
      n = 3'd4;
      case (pst)
         2'b11:   n = 3'd1;
         2'b10:   n = 3'd2;
         2'b01:   n = 3'd3;
         default: n = 3'd4;
      endcase
      prog_state = n;
   endfunction : prog_state

   function automatic logic is_state4(input logic [1:0] pst);
      is_state4 = (prog_state(pst) == 3'd4);
   endfunction : is_state4

   // Pattern at bits 3..2 for the state register slots
   function automatic logic [1:0] slot_bits(input logic [1:0] pst);
      logic [1:0] r;
      r = 2'b00;
      case (prog_state(pst))
         3'd3:    r = 2'b11;
         3'd4:    r = 2'b10;
         // States 1 and 2 share the low slot group
         default: r = 2'b00;
      endcase
      slot_bits = r;
   endfunction : slot_bits

   // ==========================================================
   // Selector register
   // ==========================================================
   // Parks at code 00 after reset, so no normal-mode access happens before a load
   logic [SEL_WIDTH-1:0] scratch_addr_selector_r;

   // [RULE1] Load on pulse
   // [RULE4] Set from lines
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         scratch_addr_selector_r <= SEL_WIDTH'(SEL_RESET);
      end else if (LOAD_PULSE_I) begin
         scratch_addr_selector_r <= SELECTOR_SET_LINES_I;
      end
   end

   assign SCRATCH_ADDR_SELECTOR_O = scratch_addr_selector_r;

   // ==========================================================
   // Address decoder
   // ==========================================================
   logic [1:0]        high_digit;
   logic [2:0]        low_digit;
   logic [ADDR_W-1:0] dec_addr;
   logic              dec_valid;
   logic [ADDR_W:0]   dec_word;
   logic [1:0]        ps;

   // [RULE5] Split into octal digits
   assign high_digit = scratch_addr_selector_r[4:3];
   assign low_digit  = scratch_addr_selector_r[2:0];
   assign ps         = SRC_I.program_state_reg;

   // Digit decoders return {valid, address}, except utility_addr, which returns the address only; valid low marks an undefined code
   // [RULE14] Digit 0x: no state bits read
   function automatic logic [ADDR_W:0] plain_word(input logic [2:0]   lo,
                                                  input spag_src_type src);
      logic [ADDR_W:0] w;
      w = {1'b1, ADDR_RESET};
      case (lo)
         // [RULE6] Whole counter
         3'd1: w[ADDR_W-1:0] = src.counter;
         // [RULE7] General field low bits
         // Field bit 3 must be zero upstream; it is not checked here
         3'd2: w[ADDR_W-1:0] = {GEN_HI_BITS, src.general_field_most[2:0]};
         3'd3: w[ADDR_W-1:0] = {GEN_HI_BITS, src.general_field_least[2:0]};
         3'd4: w[ADDR_W-1:0] = {4'h0, src.counter[5], src.counter[5], src.counter[4]};
         // [RULE17] I/O area
         // [RULE18] Live initiate/terminate bits
         3'd5: w[ADDR_W-1:0] = {src.init_term_reg[2], src.init_term_reg[1], 1'b1,
                                src.init_term_reg[0], src.counter[5],
                                src.counter[5], src.counter[4]};
         // [RULE8] Fixed locations
         3'd6: w[ADDR_W-1:0] = ADDR_PARITY;
         3'd7: w[ADDR_W-1:0] = ADDR_FIX43;
         // [RULE22] Undefined code
         default: w = {1'b0, ADDR_RESET};
      endcase
      plain_word = w;
   endfunction : plain_word

   // [RULE9] Utility words in code order, as seven-bit decoder patterns
   function automatic logic [ADDR_W-1:0] utility_addr(input logic [2:0] lo);
      logic [ADDR_W-1:0] a;
      a = ADDR_RESET;
      case (lo)
         3'd0:    a = 7'h00;
         3'd1:    a = 7'h01;
         3'd2:    a = 7'h30;
         3'd3:    a = 7'h31;
         3'd4:    a = 7'h06;
         3'd5:    a = 7'h07;
         3'd6:    a = 7'h50;
         default: a = 7'h51;
      endcase
      utility_addr = a;
   endfunction : utility_addr

   // [RULE15] Digit 2x: state on bits 6,5
   function automatic logic [ADDR_W:0] general_word(input logic [2:0]   lo,
                                                    input spag_src_type src);
      logic [1:0]        pst;
      logic [ADDR_W-1:0] a;
      pst = src.program_state_reg;
      a   = ADDR_RESET;
      case (lo)
         // [RULE10] Full general field
         3'd0:    a = {pst, 1'b0, src.general_field_most};
         3'd2:    a = {pst, 1'b0, src.general_field_least};
         // [RULE11] Odd register of the pair
         3'd1:    a = {pst, 1'b0, src.general_field_most[GEN_W-1:1], 1'b1};
         3'd3:    a = {pst, 1'b0, src.general_field_least[GEN_W-1:1], 1'b1};
         // [RULE12] State register slots
         default: a = {pst, 1'b0, slot_bits(pst), lo[1:0]};
      endcase
      general_word = {1'b1, a};
   endfunction : general_word

   // [RULE13] Digit 3x: mask, status and counter words
   // [RULE15] State on bits 5,3,2
   function automatic logic [ADDR_W:0] control_word(input logic [2:0] lo,
                                                    input logic [1:0] pst);
      logic [ADDR_W:0] w;
      w = {1'b0, ADDR_RESET};
      case (lo)
         3'd0, 3'd1, 3'd2: w = {1'b1, 1'b0, is_state4(pst), 1'b0, pst, lo[1:0]};
         // [RULE22] Codes 33..37 stay undefined
         default:          w = {1'b0, ADDR_RESET};
      endcase
      control_word = w;
   endfunction : control_word

   // One digit decoder per high digit
   always_comb begin
      dec_word = {1'b0, ADDR_RESET};
      case (high_digit)
         // [RULE14] No state dependence here
         2'b00:   dec_word = plain_word(low_digit, SRC_I);
         // [RULE9] Utility table
         2'b01:   dec_word = {1'b1, utility_addr(low_digit)};
         2'b10:   dec_word = general_word(low_digit, SRC_I);
         default: dec_word = control_word(low_digit, ps);
      endcase
   end

   assign dec_addr  = dec_word[ADDR_W-1:0];
   assign dec_valid = dec_word[ADDR_W];

   // ==========================================================
   // Fast memory address register
   // ==========================================================
   logic [ADDR_W-1:0] fast_mem_addr_bits_r;
   logic              mem_access_r;
   logic              addr_valid_r;
   logic [ADDR_W-1:0] sel_addr;
   logic              sel_valid;

   // Idle mode decodes as an undefined code and raises no access
   // [RULE19] Mode override of the source
   always_comb begin
      case (MODE_I)
         MODE_NORMAL: begin
            sel_addr  = dec_addr;
            sel_valid = dec_valid;
         end
         MODE_MUX: begin
            sel_addr  = MUX_SCRATCH_ADDR_REG_I;
            sel_valid = 1'b1;
         end
         MODE_SELCHAN: begin
            sel_addr  = SELCHAN_SCRATCH_ADDR_REG_I;
            sel_valid = 1'b1;
         end
         default: begin
            sel_addr  = ADDR_RESET;
            sel_valid = 1'b0;
         end
      endcase
   end

   // [RULE2] Capture on access pulse
   // [RULE3] Decoder into address register
   // [RULE23] Hold until access done
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         fast_mem_addr_bits_r <= ADDR_RESET;
         addr_valid_r         <= 1'b0;
      end else if (ACCESS_PULSE_I) begin
         // [RULE22] Zero address for undefined
         fast_mem_addr_bits_r <= sel_valid ? sel_addr : ADDR_RESET;
         addr_valid_r         <= sel_valid;
      end
   end

   // Access stays up until done; a new pulse wins over done
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         mem_access_r <= 1'b0;
      end else if (ACCESS_PULSE_I) begin
         // [RULE22] No access for undefined
         mem_access_r <= sel_valid;
      end else if (ACCESS_DONE_I) begin
         mem_access_r <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Address only moves on a pulse or on reset, so it holds through an access that no reset cuts short
   assign FAST_MEM_ADDR_BITS_O = fast_mem_addr_bits_r;
   assign MEM_ACCESS_O         = mem_access_r;
   assign ADDR_VALID_O         = addr_valid_r;
endmodule : spag_addr_gen

// File: verif/spag_addr_gen_chk.sv
// Purpose: Port checks for the scratch pad address generator
// Assumes: One clock, synchronous active-high reset
// Notes:   Selector codes are octal values written in hex
`timescale 1ns/1ps
module spag_addr_gen_chk import spag_pkg::*; #(
   parameter int SEL_WIDTH = SEL_W
) (
   input wire logic                    CLK_I,
   input wire logic                    SRST_I,
   input wire logic                    LOAD_PULSE_I,
   input wire logic                    ACCESS_PULSE_I,
   input wire logic                    ACCESS_DONE_I,
   input wire logic [SEL_WIDTH-1:0]    SELECTOR_SET_LINES_I,
   input wire spag_pkg::spag_mode_type MODE_I,
   input wire spag_pkg::spag_src_type  SRC_I,
   input wire logic [ADDR_W-1:0]       MUX_SCRATCH_ADDR_REG_I,
   input wire logic [ADDR_W-1:0]       SELCHAN_SCRATCH_ADDR_REG_I,
   input wire logic [SEL_WIDTH-1:0]    SCRATCH_ADDR_SELECTOR_O,
   input wire logic [ADDR_W-1:0]       FAST_MEM_ADDR_BITS_O,
   input wire logic                    MEM_ACCESS_O,
   input wire logic                    ADDR_VALID_O
);
   wire       an = ACCESS_PULSE_I && MODE_I == MODE_NORMAL;
   wire [4:0] sl = 5'(SCRATCH_ADDR_SELECTOR_O);
   wire [4:0] sn = 5'(SELECTOR_SET_LINES_I);
   wire [6:0] fa = FAST_MEM_ADDR_BITS_O;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   // ========================================
   // Checks
   AST_LOAD: assert property (LOAD_PULSE_I |=> sl == $past(sn)) else $error("sel load");
   AST_CTR: assert property (an && sl == 5'h01 |=> fa == $past(SRC_I.counter))
      else $error("counter addr");
   AST_GENHI: assert property (an && sl[4:1] == 4'h1 |=> fa[6:3] == 4'he)
      else $error("general high bits");
   AST_PSR: assert property (an && sl[4:3] == 2'b10 |=> fa[6:5] == $past(SRC_I.program_state_reg))
      else $error("state bits");
   AST_UNDEF: assert property (an && sl == 5'h00 |=> fa == 7'h00 && !MEM_ACCESS_O && !ADDR_VALID_O)
      else $error("undefined code");
   AST_MUX: assert property (ACCESS_PULSE_I && MODE_I == MODE_MUX |=> fa == $past(MUX_SCRATCH_ADDR_REG_I))
      else $error("mux addr");
   AST_HOLD: assert property (!ACCESS_PULSE_I && !SRST_I |=> $stable(fa))
      else $error("addr moved");
   AST_BUSY: assert property (MEM_ACCESS_O && !ACCESS_DONE_I && !ACCESS_PULSE_I && !SRST_I
      |=> MEM_ACCESS_O) else $error("access dropped");
   cover property (an && sl == 5'h01);
   cover property (ACCESS_PULSE_I && MODE_I == MODE_SELCHAN);
   cover property (MEM_ACCESS_O && ACCESS_DONE_I);
endmodule : spag_addr_gen_chk

// File: verif/spag_fm_model.sv
// Purpose: Fast memory side answering each scratch pad access
// Assumes: An access is open while the busy level is high
// Notes:   Wait count gives a prompt or a slow answer
`timescale 1ns/1ps
module spag_fm_model import spag_pkg::*; (
   input  wire logic              clk_i,
   input  wire logic              mem_access_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [3:0]        wait_i,
   output logic                   done_o,
   output logic [ADDR_W-1:0]      seen_addr_o
);
   logic [3:0] cnt_r = 4'h0;
   wire        hit = mem_access_i && !done_o && cnt_r == wait_i;
   // ========================================
   // Answer
   always_ff @(posedge clk_i) begin
      done_o <= hit;
      cnt_r <= (mem_access_i && !done_o && !hit) ? cnt_r + 4'h1 : 4'h0;
      if (hit) seen_addr_o <= addr_i;
   end
endmodule : spag_fm_model

// File: verif/test_scratch_pad_address_gen.sv
// Purpose: Load and access sequences against the decode table
// Assumes: Pulses driven as the command logic would drive them
// Notes:   Mode address inputs stay fixed
`timescale 1ns/1ps
module test_scratch_pad_address_gen;
   import spag_pkg::*;
   localparam logic [63:0] UTIL = 64'hd1d0_8786_b1b0_8180;
   logic          clk = 1'b0;
   logic          srst = 1'b1;
   logic          ld = 1'b0;
   logic          ac = 1'b0;
   logic          dn, busy, vld;
   logic [4:0]    lines = 5'h00;
   logic [4:0]    sel;
   logic [6:0]    addr, seen;
   logic [6:0]    mxa = 7'h2d;
   logic [6:0]    sca = 7'h52;
   logic [3:0]    wt = 4'h0;
   spag_mode_type mode = MODE_NORMAL;
   spag_src_type  src = '0;
   int            num_errors = 0;
   int            checks = 0;
   spag_addr_gen #(.SEL_WIDTH(SEL_W)) DUT (.CLK_I(clk), .SRST_I(srst), .LOAD_PULSE_I(ld),
      .ACCESS_PULSE_I(ac), .ACCESS_DONE_I(dn), .SELECTOR_SET_LINES_I(lines), .MODE_I(mode),
      .SRC_I(src), .MUX_SCRATCH_ADDR_REG_I(mxa), .SELCHAN_SCRATCH_ADDR_REG_I(sca),
      .SCRATCH_ADDR_SELECTOR_O(sel), .FAST_MEM_ADDR_BITS_O(addr), .MEM_ACCESS_O(busy),
      .ADDR_VALID_O(vld));
   spag_fm_model u_fm (.clk_i(clk), .mem_access_i(busy), .addr_i(addr), .wait_i(wt),
      .done_o(dn), .seen_addr_o(seen));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(string what, logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic summarize();
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // ========================================
   // Expected {valid, address}
   function automatic logic [7:0] model_addr(logic [4:0] s, spag_src_type r);
      logic [1:0] ps;
      logic [6:0] c;
      ps = r.program_state_reg;
      c = r.counter;
      if (s[4:2] == 3'b101) return {1'b1, ps, 1'b0, ~ps[1], ps == 2'b01, s[1:0]};
      if (s[4:2] == 3'b100) return {1'b1, ps, 1'b0, s[1] ? r.general_field_least[3:1] :
         r.general_field_most[3:1], s[0] | (s[1] ? r.general_field_least[0] :
         r.general_field_most[0])};
      if (s[4:3] == 2'b01) return UTIL[8 * s[2:0] +: 8];
      if (s[4:3] == 2'b11 && s[2:0] < 3'h3) return {2'b10, ps == 2'b00, 1'b0, ps, s[1:0]};
      case (s)
         5'h01: return {1'b1, c};
         5'h02: return {1'b1, 4'he, r.general_field_most[2:0]};
         5'h03: return {1'b1, 4'he, r.general_field_least[2:0]};
         5'h04: return {5'h10, c[5], c[5:4]};
         5'h05: return {1'b1, r.init_term_reg[2:1], 1'b1, r.init_term_reg[0], c[5], c[5:4]};
         5'h06: return 8'hf0;
         5'h07: return 8'hc3;
         default: return 8'h00;
      endcase
   endfunction : model_addr
   task automatic op(logic [4:0] s, spag_mode_type m, spag_src_type r, logic [7:0] exp,
                     logic same = 1'b0);
      @(posedge clk);
      ld <= 1'b1;
      lines <= s;
      mode <= m;
      src <= r;
      ac <= same;
      @(posedge clk);
      ld <= 1'b0;
      ac <= !same;
      if (!same) begin
         @(posedge clk);
         ac <= 1'b0;
      end
      #1;
      check("selector", sel, s);
      check("address", {vld, addr}, exp);
      check("busy", busy, exp[7]);
      for (int i = 0; i < 20 && busy !== 1'b0; i++) #25;
      check("done", busy, 1'b0);
      if (exp[7]) check("fm address", seen, exp[6:0]);
   endtask : op
   initial begin
      spag_src_type r;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (int s = 0; s < 32; s++) begin
         for (int p = 0; p < 4; p++) begin
            r = '{7'(91 + 39 * p), {s[4], 3'(p + 1)}, {s[4], 3'(6 - p)}, 2'(p), 3'(p + 5)};
            wt <= 4'(2 * p);
            op(5'(s), MODE_NORMAL, r, model_addr(5'(s), r));
         end
      end
      op(5'h01, MODE_MUX, r, {1'b1, mxa});
      op(5'h01, MODE_SELCHAN, r, {1'b1, sca});
      op(5'h06, MODE_IDLE, r, 8'h00);
      op(5'h07, MODE_NORMAL, r, 8'hc3);
      op(5'h06, MODE_NORMAL, r, 8'hc3, 1'b1);
      // Reset lands while an access is still open
      @(posedge clk);
      ac <= 1'b1;
      @(posedge clk);
      ac <= 1'b0;
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      #1;
      check("reset", {sel, addr, busy, vld}, 16'h0000);
      op(5'h05, MODE_NORMAL, r, model_addr(5'h05, r));
      summarize();
   end
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      summarize();
   end
endmodule : test_scratch_pad_address_gen
bind spag_addr_gen spag_addr_gen_chk #(.SEL_WIDTH(SEL_WIDTH)) u_chk (.*);
